// *** verilog/oms_pkg.sv ***
// Package of constants and types for the operating-mode sequencer.
package oms_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned LAMP_MIN_SEC    = 3;
	localparam int unsigned BLINK_HALF_MS   = 250;
	localparam int unsigned LAMP_MIN_CYC    = LAMP_MIN_SEC * CLK_HZ;
	localparam int unsigned BLINK_HALF_CYC  = (BLINK_HALF_MS * (CLK_HZ / 1000));
	localparam int unsigned CNT_W           = 32;

	// ==========================================================
	// Breakpoints
	// ==========================================================
	localparam int unsigned BP_MAX          = 3;
	localparam int unsigned BP_STEP_MAX     = 2;
	localparam int unsigned BP_CNT_W        = 2;

	// ==========================================================
	// Modes and execution phases
	// ==========================================================
	typedef enum logic [1:0] {
		OMS_STOP    = 2'b00,
		OMS_STARTUP = 2'b01,
		OMS_RUN     = 2'b10,
		OMS_HOLD    = 2'b11
	} oms_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE     = 3'b000,
		PH_CLR_IN   = 3'b001,
		PH_STARTUP  = 3'b010,
		PH_CLR_OUT  = 3'b011,
		PH_READ_IN  = 3'b100,
		PH_MAIN     = 3'b101
	} oms_phase_t;

	// Strobes toward the execution engine, one cycle each.
	typedef struct packed {
		logic clearInputImage;
		logic startStartupBlock;
		logic clearOutputImage;
		logic readInputs;
		logic startMainBlock;
		logic stepStatement;
	} oms_exec_t;

	// Lamp and inhibit outputs.
	typedef struct packed {
		logic outputInhibit;
		logic runLamp;
		logic stopLamp;
	} oms_lamp_t;

endpackage

// *** verilog/oms_sequencer.sv ***
// Operating-mode sequencer: stop, start-up, run and hold with lamps and inhibit.
module oms_sequencer
	import oms_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// Mode switch and software commands
	input  wire logic             runRequest,
	input  wire logic             stepRequest,
	input  wire logic             resumeRequest,
	input  wire logic             errorStop,
	// Breakpoint bookkeeping
	input  wire logic [BP_CNT_W-1:0] bpDefined,
	input  wire logic             bpActive,
	input  wire logic             bpHit,
	// Execution engine handshake
	input  wire logic             startupDone,
	input  wire logic             mainDone,
	input  wire logic             stepDone,
	output oms_exec_t             execStrobe,
	output logic                  timersEnable,
	output logic                  registersVisible,
	output logic                  stepRefused,
	// Mode, lamps and inhibit
	output oms_mode_t             mode,
	output oms_lamp_t             lamps
);

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	// Mode switch and commands may come from outside; all pass two flops.
	localparam int unsigned SYNC_W = 6 + BP_CNT_W;
	logic [SYNC_W-1:0] syncA_q;
	logic [SYNC_W-1:0] syncB_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			syncA_q <= {runRequest, stepRequest, resumeRequest, errorStop,
				bpActive, bpHit, bpDefined};
			syncB_q <= syncA_q;
		end
	end

	logic                runS;
	logic                stepS;
	logic                resumeS;
	logic                errS;
	logic                bpActS;
	logic                bpHitS;
	logic [BP_CNT_W-1:0] bpDefS;
	assign {runS, stepS, resumeS, errS, bpActS, bpHitS, bpDefS} = syncB_q;

	// Step and resume act on their rising edge so a held level does one thing.
	logic stepPrev_q;
	logic resumePrev_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stepPrev_q   <= 1'b0;
			resumePrev_q <= 1'b0;
		end else begin
			stepPrev_q   <= stepS;
			resumePrev_q <= resumeS;
		end
	end
	logic stepEdge;
	logic resumeEdge;
	assign stepEdge   = stepS & ~stepPrev_q;
	assign resumeEdge = resumeS & ~resumePrev_q;

	// A breakpoint hit counts only while the defined count is within the supported maximum.
	logic bpHitValid;
	assign bpHitValid = bpHitS & bpActS & (32'(bpDefS) <= BP_MAX);

	// ==========================================================
	// Mode and phase machine
	// ==========================================================
	oms_mode_t  mode_q;
	oms_mode_t  mode_d;
	oms_phase_t phase_q;
	oms_phase_t phase_d;
	logic       stepping_q;
	logic       stepping_d;
	oms_exec_t  exec_d;
	logic       refuse_d;

	always_comb begin
		mode_d     = mode_q;
		phase_d    = phase_q;
		stepping_d = stepping_q;
		exec_d     = '0;
		refuse_d   = 1'b0;
		case (mode_q)
			OMS_STOP: begin
				// Nothing is cleared here, so all retained state survives stop.
				phase_d = PH_IDLE;
				if (runS && !errS) begin
					mode_d                 = OMS_STARTUP;
					phase_d                = PH_CLR_IN;
					exec_d.clearInputImage = 1'b1;
				end
			end
			OMS_STARTUP: begin
				// No watchdog counts here: start-up may run as long as it needs.
				if (errS || !runS) begin
					mode_d  = OMS_STOP;
					phase_d = PH_IDLE;
				end else if (phase_q == PH_CLR_IN) begin
					phase_d                  = PH_STARTUP;
					exec_d.startStartupBlock = 1'b1;
				end else if (startupDone) begin
					mode_d                  = OMS_RUN;
					phase_d                 = PH_CLR_OUT;
					exec_d.clearOutputImage = 1'b1;
				end
			end
			OMS_RUN: begin
				if (errS || !runS) begin
					mode_d  = OMS_STOP;
					phase_d = PH_IDLE;
				end else if (bpHitValid && phase_q == PH_MAIN) begin
					mode_d     = OMS_HOLD;
					stepping_d = 1'b0;
				end else begin
					case (phase_q)
						PH_CLR_OUT: begin
							phase_d           = PH_READ_IN;
							exec_d.readInputs = 1'b1;
						end
						PH_READ_IN: begin
							phase_d               = PH_MAIN;
							exec_d.startMainBlock = 1'b1;
						end
						PH_MAIN: begin
							if (mainDone) begin
								phase_d                 = PH_CLR_OUT;
								exec_d.clearOutputImage = 1'b1;
							end
						end
						default: begin
							phase_d                 = PH_CLR_OUT;
							exec_d.clearOutputImage = 1'b1;
						end
					endcase
				end
			end
			OMS_HOLD: begin
				if (errS || !runS) begin
					mode_d     = OMS_STOP;
					phase_d    = PH_IDLE;
					stepping_d = 1'b0;
				end else if (stepping_q) begin
					if (stepDone) begin
						stepping_d = 1'b0;
					end
				end else if (resumeEdge) begin
					mode_d = OMS_RUN;
				end else if (stepEdge) begin
					if (32'(bpDefS) > BP_STEP_MAX) begin
						refuse_d = 1'b1;
					end else begin
						stepping_d           = 1'b1;
						exec_d.stepStatement = 1'b1;
					end
				end
			end
			default: begin
				mode_d  = OMS_STOP;
				phase_d = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q     <= OMS_STOP;
			phase_q    <= PH_IDLE;
			stepping_q <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			phase_q    <= phase_d;
			stepping_q <= stepping_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			execStrobe  <= '0;
			stepRefused <= 1'b0;
		end else begin
			execStrobe  <= exec_d;
			stepRefused <= refuse_d;
		end
	end

	// Timers run only in run; hold freezes them.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timersEnable     <= 1'b0;
			registersVisible <= 1'b0;
		end else begin
			timersEnable     <= (mode_d == OMS_RUN);
			registersVisible <= (mode_d == OMS_HOLD);
		end
	end

	// ==========================================================
	// Lamp timing
	// ==========================================================
	// The minimum-blink counter is not tied to the mode so an early stop
	// still shows the start-up indication for its full length.
	logic [CNT_W-1:0] minBlink_q;
	logic [CNT_W-1:0] blinkDiv_q;
	logic             blinkPhase_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			minBlink_q <= '0;
		end else if (exec_d.startStartupBlock) begin
			minBlink_q <= CNT_W'(LAMP_MIN_CYC);
		end else if (minBlink_q != '0) begin
			minBlink_q <= minBlink_q - CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			blinkDiv_q   <= '0;
			blinkPhase_q <= 1'b0;
		end else if (blinkDiv_q == CNT_W'(BLINK_HALF_CYC - 1)) begin
			blinkDiv_q   <= '0;
			blinkPhase_q <= ~blinkPhase_q;
		end else begin
			blinkDiv_q <= blinkDiv_q + CNT_W'(1);
		end
	end

	oms_lamp_t lamps_d;
	always_comb begin
		lamps_d = '0;
		case (mode_d)
			OMS_STOP: begin
				lamps_d.outputInhibit = 1'b1;
				lamps_d.stopLamp      = 1'b1;
			end
			OMS_STARTUP: begin
				lamps_d.outputInhibit = 1'b1;
				lamps_d.runLamp       = ~blinkPhase_q;
			end
			OMS_RUN: begin
				lamps_d.outputInhibit = 1'b0;
				lamps_d.runLamp       = 1'b1;
			end
			OMS_HOLD: begin
				lamps_d.outputInhibit = 1'b1;
				lamps_d.runLamp       = ~blinkPhase_q;
				lamps_d.stopLamp      = 1'b1;
			end
			default: begin
				lamps_d.outputInhibit = 1'b1;
			end
		endcase
		if (minBlink_q != '0) begin
			lamps_d.runLamp = ~blinkPhase_q;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lamps <= '{outputInhibit: 1'b1, runLamp: 1'b0, stopLamp: 1'b1};
			mode  <= OMS_STOP;
		end else begin
			lamps <= lamps_d;
			mode  <= mode_d;
		end
	end

endmodule

// *** verification/oms_sequencer_sva.sv ***
// Assertion checker for the operating-mode sequencer, bound to its ports.
module oms_sequencer_sva
	import oms_pkg::*;
(
	// Clock and reset
	input wire logic      clk,
	input wire logic      arst_n,
	// Observed signals
	input wire logic      startupDone,
	input wire logic      mainDone,
	input wire oms_exec_t execStrobe,
	input wire logic      timersEnable,
	input wire logic      registersVisible,
	input wire logic      stepRefused,
	input wire oms_mode_t mode,
	input wire oms_lamp_t lamps
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// Sequences
	// ==========================================================
	sequence sCycle;
		execStrobe.clearOutputImage ##1 execStrobe.readInputs ##1 execStrobe.startMainBlock;
	endsequence
	sequence sStart;
		mode == OMS_STARTUP ##1 execStrobe.startStartupBlock;
	endsequence
	// ==========================================================
	// Properties
	// ==========================================================
	chk_stop_lamps: assert property (mode == OMS_STOP |->
		lamps.outputInhibit && lamps.stopLamp)
		else $error("stop mode without inhibit or stop lamp");
	chk_stop_no_exec: assert property (mode == OMS_STOP && $past(mode) == OMS_STOP |->
		execStrobe == '0)
		else $error("execution strobe in stop mode");
	chk_startup_inhibit: assert property (mode == OMS_STARTUP |->
		lamps.outputInhibit && !lamps.stopLamp)
		else $error("start-up mode lamps or inhibit wrong");
	chk_run_release: assert property (mode == OMS_RUN |->
		!lamps.outputInhibit && !lamps.stopLamp && timersEnable)
		else $error("run mode lamps, inhibit or timers wrong");
	chk_hold_freeze: assert property (mode == OMS_HOLD |->
		lamps.outputInhibit && lamps.stopLamp && registersVisible && !timersEnable)
		else $error("hold mode state wrong");
	chk_startup_first: assert property (execStrobe.clearInputImage |-> sStart)
		else $error("start-up block not called after input clear");
	chk_startup_to_run: assert property (startupDone && mode == OMS_STARTUP |=>
		mode == OMS_RUN ##0 sCycle)
		else $error("start-up completion did not start the cycle");
	chk_main_repeat: assert property (mainDone && mode == OMS_RUN |=> sCycle)
		else $error("main block pass not followed by a new cycle");
	chk_step_refuse: assert property (stepRefused |->
		mode == OMS_HOLD && !execStrobe.stepStatement)
		else $error("refused step outside hold or with step strobe");
endmodule
bind oms_sequencer oms_sequencer_sva u_sva (.clk(clk), .arst_n(arst_n), .startupDone(startupDone),
	.mainDone(mainDone), .execStrobe(execStrobe), .timersEnable(timersEnable),
	.registersVisible(registersVisible), .stepRefused(stepRefused), .mode(mode), .lamps(lamps));

// *** verification/tb_oms_sequencer.sv ***
// Self-checking testbench for the operating-mode sequencer.
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_oms_sequencer
	import oms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n, runRequest, stepRequest, resumeRequest, errorStop;
	logic [BP_CNT_W-1:0] bpDefined;
	logic bpActive, bpHit, startupDone, mainDone, stepDone;
	logic timersEnable, registersVisible, stepRefused;
	logic [3:0] modeSeen;
	oms_exec_t execStrobe;
	oms_mode_t mode, lastMode = OMS_STOP;
	oms_lamp_t lamps;
	logic [3:0] mq[$];
	logic [6:0] sq[$];
	logic [7:0] rnd = 8'h57;
	int n_mismatch = 0, checked = 0;
	always #5 clk = ~clk;
	assign modeSeen = {mode, lamps.outputInhibit, lamps.stopLamp};
	oms_sequencer dut (.clk(clk), .arst_n(arst_n), .runRequest(runRequest), .stepRequest(stepRequest),
		.resumeRequest(resumeRequest), .errorStop(errorStop), .bpDefined(bpDefined),
		.bpActive(bpActive), .bpHit(bpHit), .startupDone(startupDone), .mainDone(mainDone),
		.stepDone(stepDone), .execStrobe(execStrobe), .timersEnable(timersEnable),
		.registersVisible(registersVisible), .stepRefused(stepRefused), .mode(mode), .lamps(lamps));
	// ==========================================================
	// Helpers
	// ==========================================================
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task test_done();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Waits until every noted result has been seen.
	task drain(input string nm);
		int i;
		for (i = 0; i < 400 && (mq.size() + sq.size()) > 0; i++) cyc(1);
		if (i == 400) begin
			n_mismatch++;
			$display("ERROR %s timed out", nm);
			test_done();
		end else begin
			$display("test %s done", nm);
		end
	endtask
	// The blink starts lit and its half period outlasts this run, so it reads lit.
	always @(posedge clk) begin
		#2;
		if (arst_n && mode !== lastMode) begin
			lastMode = mode;
			`CHK("mode", mq.size() ? mq.pop_front() : 4'hx, modeSeen)
		end
		if (arst_n && {execStrobe, stepRefused} !== 7'h00)
			`CHK("strobe", sq.size() ? sq.pop_front() : 7'hxx, {execStrobe, stepRefused})
	end
	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		arst_n = 1'b0;
		{runRequest, stepRequest, resumeRequest, errorStop} = '0;
		bpDefined = '0;
		{bpActive, bpHit, startupDone, mainDone, stepDone} = '0;
		cyc(8);
		arst_n = 1;
		cyc(1);
		`CHK("reset", {OMS_STOP, 2'b11}, modeSeen)
		`CHK("reset lamp", 1'b0, lamps.runLamp)
		mq.push_back({OMS_STARTUP, 2'b10});
		sq.push_back(7'h40);
		sq.push_back(7'h20);
		runRequest = 1;
		drain("startup");
		`CHK("startup blink", 1'b1, lamps.runLamp)
		rnd = lfsr(rnd);
		cyc(150 + int'(rnd[5:0]));
		mq.push_back({OMS_RUN, 2'b00});
		sq.push_back(7'h10);
		sq.push_back(7'h08);
		sq.push_back(7'h04);
		startupDone = 1;
		cyc(1);
		startupDone = 0;
		drain("run entry");
		repeat (2) begin
			rnd = lfsr(rnd);
			cyc(1 + int'(rnd[3:0]));
			sq.push_back(7'h10);
			sq.push_back(7'h08);
			sq.push_back(7'h04);
			mainDone = 1;
			cyc(1);
			mainDone = 0;
			drain("cycle");
		end
		mq.push_back({OMS_HOLD, 2'b11});
		bpDefined = 2'h1;
		bpActive = 1;
		bpHit = 1;
		drain("breakpoint");
		bpHit = 0;
		rnd = lfsr(rnd);
		bpDefined = 2'(rnd % 3);
		sq.push_back(7'h02);
		stepRequest = 1;
		drain("step");
		stepDone = 1;
		cyc(1);
		stepDone = 0;
		stepRequest = 0;
		bpDefined = 2'h3;
		cyc(4);
		sq.push_back(7'h01);
		stepRequest = 1;
		drain("refused step");
		stepRequest = 0;
		mq.push_back({OMS_RUN, 2'b00});
		resumeRequest = 1;
		drain("resume");
		resumeRequest = 0;
		mq.push_back({OMS_STOP, 2'b11});
		errorStop = 1;
		drain("error stop");
		`CHK("stop blink", 1'b1, lamps.runLamp)
		runRequest = 0;
		errorStop = 0;
		cyc(30);
		mq.push_back({OMS_STARTUP, 2'b10});
		sq.push_back(7'h40);
		sq.push_back(7'h20);
		runRequest = 1;
		drain("restart");
		mq.push_back({OMS_STOP, 2'b11});
		runRequest = 0;
		drain("switch stop");
		test_done();
	end
endmodule
